// File: hdl/freq_monitor.sv
// Operation
// - enable and limit writes blocked unless key holds unlock code
// - enable code starts monitoring when unlocked
// - limit pair follows the pll select bit
// - stop mode suspends, resumes after warm-up
// - monitoring only in normal and idle
// - monitor reset puts io pins high-impedance
// - only main reset clears registers, disabled
// - enable survives watchdog, cpu and own resets
// - first check after two 128-period cycles
// - out-of-range frequency requests a reset
// - request follows detection by one cycle
// - own reset leaves monitor running, bypass limits
// - limit equals frequency ratio times 32
// - unknown key write stores the lock code
// - unknown enable write is ignored
// - limit writes ignored while monitor operates
// - own reset with pll on forces bypass pair
`timescale 1ns/1ps
module freq_monitor #(
   parameter int CNT_W = 12
) (
   // clock and reset
   input  wire logic                                  i_clk,
   input  wire logic                                  i_rst,
   input  wire logic                                  i_ce,
   // wishbone slave
   input  wire logic                                  i_wb_cyc,
   input  wire logic                                  i_wb_stb,
   input  wire logic                                  i_wb_we,
   input  wire logic [freq_monitor_pkg::ADR_W-1:0]    i_wb_adr,
   input  wire logic [3:0]                            i_wb_sel,
   input  wire logic [31:0]                           i_wb_dat,
   output logic      [31:0]                           o_wb_dat,
   output logic                                       o_wb_ack,
   // clock generator and mode
   input  wire logic                                  i_monitored_clock,
   input  wire logic                                  i_pll_select_bit,
   input  wire logic                                  i_stop_mode,
   input  wire logic                                  i_warmup,
   // reset controller
   input  wire logic                                  i_sys_reset_done,
   output logic                                       o_reset_req,
   output logic                                       o_io_hiz
);
   import freq_monitor_pkg::*;

   if (CNT_W < LIMIT_W + SCALE_SHIFT + 1) begin : g_bad_width
      $error("CNT_W too small for the limit range");
   end

   ////////////////////////////////////////////////////////////////////////////////
   // register bus

   function automatic logic hit(input logic [ADR_W-1:0] adr, input logic [7:0] off);
      hit = (adr == off);
   endfunction

   logic                 ack_q;
   logic [31:0]          rd_q;
   logic                 bus_req;
   logic                 wr_go;
   logic [KEY_W-1:0]     key_q;
   logic [KEY_W-1:0]     en_q;
   logic [LIMIT_W-1:0]   lim_q [LIMIT_COUNT];
   logic                 unlocked;
   logic                 operating;
   logic [31:0]          rd_d;

   assign bus_req  = i_wb_cyc & i_wb_stb;
   // commit on the edge where the master sees ack
   assign wr_go    = bus_req & i_wb_we & ack_q & i_ce;
   assign o_wb_ack = ack_q;
   assign o_wb_dat = rd_q;

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         ack_q <= 1'b0;
      end else if (i_ce) begin
         ack_q <= bus_req & ~ack_q;
      end
   end

   always_comb begin
      rd_d = 32'h0000_0000;
      if (hit(i_wb_adr, ADR_KEY)) begin
         rd_d[KEY_W-1:0] = key_q;
      end else if (hit(i_wb_adr, ADR_ENABLE)) begin
         rd_d[KEY_W-1:0] = en_q;
      end
      for (int i = 0; i < LIMIT_COUNT; i++) begin
         if (hit(i_wb_adr, 8'(ADR_LIMIT_BASE + 8'(i * LIMIT_STRIDE)))) begin
            rd_d[LIMIT_W-1:0] = lim_q[i];
         end
      end
   end

   // reads stay open while writes are locked
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         rd_q <= 32'h0000_0000;
      end else if (i_ce && bus_req && !ack_q) begin
         rd_q <= rd_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // control registers; only i_rst (pin, power-on, voltage drop) clears them

   assign unlocked  = (key_q == KEY_UNLOCK);
   assign operating = (en_q == DETECT_ON);

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         key_q <= KEY_RST;
      end else if (wr_go && i_wb_sel[0] && hit(i_wb_adr, ADR_KEY)) begin
         if ((i_wb_dat[7:0] == KEY_UNLOCK) || (i_wb_dat[7:0] == KEY_LOCK)) begin
            key_q <= i_wb_dat[7:0];
         end else begin
            key_q <= KEY_LOCK;
         end
      end
   end

   // watchdog, cpu or own resets never reach here, so enable persists
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         en_q <= ENABLE_RST;
      end else if (wr_go && i_wb_sel[0] && unlocked && hit(i_wb_adr, ADR_ENABLE)) begin
         if ((i_wb_dat[7:0] == DETECT_ON) || (i_wb_dat[7:0] == DETECT_OFF)) begin
            en_q <= i_wb_dat[7:0];
         end
      end
   end

   for (genvar g = 0; g < LIMIT_COUNT; g++) begin : g_limit
      logic sel_this;
      assign sel_this = wr_go && unlocked && !operating
                        && hit(i_wb_adr, 8'(ADR_LIMIT_BASE + 8'(g * LIMIT_STRIDE)));
      always_ff @(posedge i_clk) begin
         if (i_rst) begin
            lim_q[g] <= LIMIT_RST[g];
         end else if (sel_this) begin
            if (i_wb_sel[0]) begin
               lim_q[g][7:0] <= i_wb_dat[7:0];
            end
            if (i_wb_sel[1]) begin
               lim_q[g][8] <= i_wb_dat[8];
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // limit pair selection

   logic               byp_q;
   logic               use_active;
   logic [LIMIT_W-1:0] low_lim;
   logic [LIMIT_W-1:0] high_lim;
   logic               req_d;
   logic               req_q;

   assign use_active = i_pll_select_bit & ~byp_q;
   assign low_lim    = use_active ? lim_q[LIM_LOW_ACT]  : lim_q[LIM_LOW_BYP];
   assign high_lim   = use_active ? lim_q[LIM_HIGH_ACT] : lim_q[LIM_HIGH_BYP];

   // holds bypass pair until the clock generator has dropped its pll select
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         byp_q <= 1'b0;
      end else if (i_ce) begin
         if (req_d && i_pll_select_bit) begin
            byp_q <= 1'b1;
         end else if (!i_pll_select_bit) begin
            byp_q <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // measurement

   logic               mon_level;
   logic [CNT_W-1:0]   edge_count;
   logic [CNT_W-1:0]   measured;
   logic               active;
   logic               win_end;
   logic               out_range;
   logic [WIN_W-1:0]   win_q;
   logic               pending_q;
   mon_state_type      state_q;

   // the monitored clock must stay below half the reference rate
   level_sync #(
      .W       (1)
   ) u_mon_sync (
      .i_clk   (i_clk),
      .i_rst   (i_rst),
      .i_ce    (i_ce),
      .i_async (i_monitored_clock),
      .o_sync  (mon_level)
   );

   edge_ratio_counter #(
      .CNT_W   (CNT_W)
   ) u_counter (
      .i_clk   (i_clk),
      .i_rst   (i_rst),
      .i_ce    (i_ce),
      .i_level (mon_level),
      .i_clear ((state_q == ST_IDLE) || win_end),
      .o_count (edge_count)
   );

   assign active    = operating & ~i_stop_mode & ~i_warmup;
   assign win_end   = active && (state_q != ST_IDLE) && (win_q == WIN_LAST);
   // 128-period count scaled to the x32 limit units
   assign measured  = edge_count >> SCALE_SHIFT;
   assign out_range = (measured < CNT_W'(low_lim)) || (measured > CNT_W'(high_lim));

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         state_q <= ST_IDLE;
      end else if (i_ce) begin
         case (state_q)
            ST_IDLE:  if (active) state_q <= ST_FIRST;
            ST_FIRST: if (!active) state_q <= ST_IDLE;
                      else if (win_end) state_q <= ST_CHECK;
            ST_CHECK: if (!active) state_q <= ST_IDLE;
            default:  state_q <= ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         win_q <= '0;
      end else if (i_ce) begin
         if (!active || (state_q == ST_IDLE)) begin
            win_q <= '0;
         end else begin
            win_q <= win_q + WIN_W'(1);
         end
      end
   end

   // checking goes on through the monitor's own reset
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         pending_q <= 1'b0;
      end else if (i_ce) begin
         if (!active) begin
            pending_q <= 1'b0;
         end else if (win_end && (state_q == ST_CHECK)) begin
            pending_q <= out_range;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // reset request and pin release

   assign req_d       = win_end && (state_q == ST_CHECK) && pending_q;
   assign o_reset_req = req_q;

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         req_q <= 1'b0;
      end else if (i_ce) begin
         req_q <= req_d;
      end
   end

   // set wins over the controller's release
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_io_hiz <= 1'b0;
      end else if (i_ce) begin
         if (req_d) begin
            o_io_hiz <= 1'b1;
         end else if (i_sys_reset_done) begin
            o_io_hiz <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);

   sequence s_bad_key_write;
      wr_go && i_wb_sel[0] && hit(i_wb_adr, ADR_KEY)
      && (i_wb_dat[7:0] != KEY_UNLOCK) && (i_wb_dat[7:0] != KEY_LOCK);
   endsequence

   sequence s_bad_window;
      i_ce && win_end && (state_q == ST_CHECK) && out_range;
   endsequence

   // next check edge exactly one window on; only reached if monitoring never paused
   sequence s_check_end;
      i_ce && win_end && (state_q == ST_CHECK);
   endsequence

   a_key_relock: assert property (s_bad_key_write |=> key_q == KEY_LOCK)
      else $error("bad key write did not store lock code");
   a_enable_locked: assert property (!unlocked |=> $stable(en_q))
      else $error("enable changed while locked");
   a_enable_code: assert property ($changed(en_q) |-> operating || en_q == DETECT_OFF)
      else $error("enable took an invalid code");
   a_limit_guard: assert property (operating |=> $stable(lim_q[LIM_LOW_BYP]) && $stable(lim_q[LIM_HIGH_ACT]))
      else $error("limit written while operating");
   a_stop_suspend: assert property (i_ce && (i_stop_mode || i_warmup) |=> state_q == ST_IDLE && !o_reset_req)
      else $error("monitor ran in stop or warm-up");
   a_first_quiet: assert property (i_ce && state_q == ST_IDLE ##1 state_q == ST_FIRST |-> !o_reset_req [*8])
      else $error("request during first detecting cycle");
   a_detect_delay: assert property (s_bad_window ##128 s_check_end |=> o_reset_req)
      else $error("request not one detecting cycle after detection");
   a_req_pulse: assert property (o_reset_req |=> !o_reset_req)
      else $error("reset request longer than one cycle");
   a_hiz_follow: assert property (o_reset_req |-> o_io_hiz)
      else $error("pins not released to high impedance");
   a_bypass_pair: assert property (o_reset_req && $past(i_pll_select_bit) |-> low_lim == lim_q[LIM_LOW_BYP])
      else $error("pll-on limits kept after own reset");

endmodule

// File: hdl/freq_monitor_pkg.sv
package freq_monitor_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // register map, byte addresses
   localparam int             ADR_W          = 8;
   localparam logic [7:0]     ADR_KEY        = 8'h00;
   localparam logic [7:0]     ADR_ENABLE     = 8'h04;
   localparam logic [7:0]     ADR_LIMIT_BASE = 8'h08;
   localparam int             LIMIT_STRIDE   = 4;
   localparam int             LIMIT_COUNT    = 4;
   // limit array order
   localparam int             LIM_LOW_BYP    = 0;
   localparam int             LIM_LOW_ACT    = 1;
   localparam int             LIM_HIGH_BYP   = 2;
   localparam int             LIM_HIGH_ACT   = 3;

   ////////////////////////////////////////////////////////////////////////////////
   // field layout and codes
   localparam int             KEY_W          = 8;
   localparam int             LIMIT_W        = 9;
   localparam logic [7:0]     KEY_UNLOCK     = 8'hF9;
   localparam logic [7:0]     KEY_LOCK       = 8'h06;
   localparam logic [7:0]     DETECT_ON      = 8'hE4;
   localparam logic [7:0]     DETECT_OFF     = 8'h00;

   ////////////////////////////////////////////////////////////////////////////////
   // reset values
   localparam logic [7:0]     KEY_RST        = KEY_LOCK;
   localparam logic [7:0]     ENABLE_RST     = DETECT_OFF;
   localparam logic [8:0]     LIMIT_RST [LIMIT_COUNT] = '{9'h01D, 9'h077, 9'h025, 9'h08F};

   ////////////////////////////////////////////////////////////////////////////////
   // timing: one detecting cycle is 128 reference periods; limits are ratio x 32
   localparam int             DETECT_PERIODS = 128;
   localparam int             RATIO_SCALE    = 32;
   localparam int             WIN_W          = $clog2(DETECT_PERIODS);
   localparam logic [6:0]     WIN_LAST       = 7'(DETECT_PERIODS - 1);
   localparam int             SCALE_SHIFT    = $clog2(DETECT_PERIODS / RATIO_SCALE);

   typedef enum logic [1:0] {ST_IDLE, ST_FIRST, ST_CHECK} mon_state_type;

endpackage

// File: hdl/level_sync.sv
`timescale 1ns/1ps
module level_sync #(
   parameter int W = 1
) (
   // clock
   input  wire logic         i_clk,
   input  wire logic         i_rst,
   input  wire logic         i_ce,
   // levels
   input  wire logic [W-1:0] i_async,
   output logic      [W-1:0] o_sync
);

   logic [W-1:0] meta_q;

   // first stage feeds only the second
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         meta_q <= '0;
         o_sync <= '0;
      end else if (i_ce) begin
         meta_q <= i_async;
         o_sync <= meta_q;
      end
   end

endmodule

// File: hdl/edge_ratio_counter.sv
`timescale 1ns/1ps
module edge_ratio_counter #(
   parameter int CNT_W = 12
) (
   // clock
   input  wire logic             i_clk,
   input  wire logic             i_rst,
   input  wire logic             i_ce,
   // monitored level, already synchronised
   input  wire logic             i_level,
   input  wire logic             i_clear,
   output logic      [CNT_W-1:0] o_count
);

   logic prev_q;
   logic rise;

   assign rise = i_level & ~prev_q;

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         prev_q <= 1'b0;
      end else if (i_ce) begin
         prev_q <= i_level;
      end
   end

   // saturate so a runaway clock still reads as too fast
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_count <= '0;
      end else if (i_ce) begin
         if (i_clear) begin
            o_count <= CNT_W'(rise);
         end else if (rise && (o_count != '1)) begin
            o_count <= o_count + CNT_W'(1);
         end
      end
   end

endmodule

// File: tb/clock_gen_model.sv
`timescale 1ns/1ps
module clock_gen_model (
   // clock
   input  wire logic       i_clk,
   input  wire logic       i_rst,
   // bench control
   input  wire logic [7:0] i_half_period,
   input  wire logic       i_pll_request,
   // monitor side
   input  wire logic       i_reset_req,
   output logic            o_monitored_clock,
   output logic            o_pll_select_bit,
   output logic            o_sys_reset_done
);
   logic [7:0] tick_q;
   logic       pll_off_q;
   logic [3:0] done_cnt_q;

   ////////////////////////////////////////////////////////////////////////////////
   // external oscillator only, kept below half the reference rate
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         tick_q            <= 8'h00;
         o_monitored_clock <= 1'b0;
      end else if (tick_q + 8'h01 >= i_half_period) begin
         tick_q            <= 8'h00;
         o_monitored_clock <= ~o_monitored_clock;
      end else begin
         tick_q <= tick_q + 8'h01;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // own reset clears the generator: pll off until software drops its request
   always_ff @(posedge i_clk) begin
      if (i_rst || !i_pll_request) begin
         pll_off_q <= 1'b0;
      end else if (i_reset_req) begin
         pll_off_q <= 1'b1;
      end
   end
   assign o_pll_select_bit = i_pll_request & ~pll_off_q;

   // pins released some cycles after the request
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         done_cnt_q       <= 4'h0;
         o_sys_reset_done <= 1'b0;
      end else begin
         o_sys_reset_done <= (done_cnt_q == 4'h1);
         if (i_reset_req) begin
            done_cnt_q <= 4'h8;
         end else if (done_cnt_q != 4'h0) begin
            done_cnt_q <= done_cnt_q - 4'h1;
         end
      end
   end
endmodule

// File: tb/freq_monitor_tb.sv
`timescale 1ns/1ps
module freq_monitor_tb;
   import freq_monitor_pkg::*;
   logic        clk = 1'b0;
   logic        rst, cyc, stb, we, ack, mon, pll, stop, warm, done, req, hiz, pll_req;
   logic [7:0]  adr, half;
   logic [3:0]  sel;
   logic [31:0] wdat, rdat;
   int          failures = 0;
   int          checks_done = 0;

   always #4 clk = ~clk;

   freq_monitor u_freq_monitor (.i_clk(clk), .i_rst(rst), .i_ce(1'b1), .i_wb_cyc(cyc), .i_wb_stb(stb),
      .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack),
      .i_monitored_clock(mon), .i_pll_select_bit(pll), .i_stop_mode(stop), .i_warmup(warm),
      .i_sys_reset_done(done), .o_reset_req(req), .o_io_hiz(hiz));

   clock_gen_model u_clock_gen_model (.i_clk(clk), .i_rst(rst), .i_half_period(half),
      .i_pll_request(pll_req), .i_reset_req(req), .o_monitored_clock(mon), .o_pll_select_bit(pll),
      .o_sys_reset_done(done));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic report_and_stop;
      if (failures == 0 && checks_done > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   task automatic chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         failures++;
         $display("mismatch %s expected %h seen %h", s, exp, seen);
      end
   endtask

   // one classic cycle, held until ack is sampled high
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      int n;
      @(posedge clk);
      cyc  <= 1'b1;
      stb  <= 1'b1;
      we   <= w;
      adr  <= a;
      wdat <= d;
      sel  <= 4'hF;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 64);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      if (n >= 64) failures++;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask

   task automatic rdchk(input string s, input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, q);
      chk(s, q, exp);
   endtask

   function automatic logic [7:0] la(input int i);
      return ADR_LIMIT_BASE + 8'(LIMIT_STRIDE * i);
   endfunction

   task automatic quiet(input int c, input string s);
      int k;
      k = 0;
      repeat (c) begin
         @(posedge clk);
         if (req === 1'b1) k++;
      end
      chk(s, 32'(k), 32'h0);
   endtask

   // waits for a request, then checks pins and pulse width
   task automatic wait_req(input int mx, output int n);
      n = 0;
      while (req !== 1'b1 && n < mx) begin
         @(posedge clk);
         n++;
      end
      chk("hiz", 32'(hiz), 32'h1);
      @(posedge clk);
      chk("pulse end", 32'(req), 32'h0);
   endtask

   // limits and pll only change while disabled
   task automatic cfg(input logic [8:0] lo, input logic [8:0] hi, input logic [7:0] h, input logic act);
      wr(ADR_KEY, 32'hF9);
      wr(ADR_ENABLE, 32'h00);
      wr(la(act ? 1 : 0), 32'(lo));
      wr(la(act ? 3 : 2), 32'(hi));
      half    <= h;
      pll_req <= act;
      wr(ADR_ENABLE, 32'hE4);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_reset_values;
      logic [8:0] rv [4] = '{9'h01D, 9'h077, 9'h025, 9'h08F};
      rdchk("key", ADR_KEY, 32'h06);
      rdchk("enable", ADR_ENABLE, 32'h00);
      for (int i = 0; i < 4; i++) rdchk("limit", la(i), 32'(rv[i]));
      rdchk("unmapped", 8'h40, 32'h0);
   endtask

   task automatic t_write_lock;
      wr(la(LIM_LOW_BYP), 32'h0AA);
      wr(ADR_ENABLE, 32'hE4);
      rdchk("locked limit", la(0), 32'h01D);
      rdchk("locked enable", ADR_ENABLE, 32'h00);
      wr(ADR_KEY, 32'hF9);
      rdchk("key open", ADR_KEY, 32'hF9);
      wr(la(LIM_HIGH_ACT), 32'h1A5);
      rdchk("open limit", la(3), 32'h1A5);
      wr(ADR_KEY, 32'h55);
      rdchk("key other", ADR_KEY, 32'h06);
      wr(la(3), 32'h08F);
      rdchk("relocked limit", la(3), 32'h1A5);
   endtask

   task automatic t_enable_codes;
      wr(ADR_KEY, 32'hF9);
      wr(ADR_ENABLE, 32'h33);
      rdchk("enable bad", ADR_ENABLE, 32'h00);
      wr(ADR_ENABLE, 32'hE4);
      rdchk("enable on", ADR_ENABLE, 32'hE4);
      wr(ADR_ENABLE, 32'h5A);
      rdchk("enable kept", ADR_ENABLE, 32'hE4);
      wr(la(0), 32'h0AA);
      rdchk("running limit", la(0), 32'h01D);
      wr(ADR_ENABLE, 32'h00);
      wr(ADR_KEY, 32'h06);
   endtask

   task automatic t_range_pll;
      int n;
      cfg(9'd4, 9'd12, 8'd2, 1'b0);
      quiet(700, "in range");
      cfg(9'd8, 9'd8, 8'd2, 1'b0);
      quiet(700, "on the limits");
      cfg(9'd20, 9'd30, 8'd2, 1'b1);
      wait_req(500, n);
      chk("pll pair", 32'(n >= 376 && n <= 394), 32'h1);
      // the window that ended at the request was still judged on the pll-on pair
      wait_req(200, n);
      chk("last pll window", 32'(n >= 126 && n <= 128), 32'h1);
      // cause is the monitor itself, so software leaves it configured
      quiet(700, "after own reset");
      chk("hiz released", 32'(hiz), 32'h0);
      rdchk("enable kept", ADR_ENABLE, 32'hE4);
   endtask

   task automatic t_timing_stop;
      int n;
      cfg(9'd4, 9'd12, 8'd8, 1'b0);
      wait_req(500, n);
      chk("first check", 32'(n >= 376 && n <= 394), 32'h1);
      wait_req(200, n);
      chk("repeat", 32'(n >= 126 && n <= 128), 32'h1);
      stop <= 1'b1;
      quiet(600, "stop");
      stop <= 1'b0;
      warm <= 1'b1;
      quiet(300, "warm-up");
      warm <= 1'b0;
      wait_req(500, n);
      chk("resume", 32'(n >= 376 && n <= 394), 32'h1);
   endtask

   task automatic t_main_reset;
      rst <= 1'b1;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      rdchk("enable cleared", ADR_ENABLE, 32'h00);
      rdchk("key cleared", ADR_KEY, 32'h06);
      quiet(400, "disabled");
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      {cyc, stb, we, stop, warm, pll_req} = '0;
      rst  = 1'b1;
      adr  = 8'h00;
      sel  = 4'h0;
      wdat = 32'h0;
      half = 8'd2;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      t_reset_values();
      t_write_lock();
      t_enable_codes();
      t_range_pll();
      t_timing_stop();
      t_main_reset();
      report_and_stop();
   end

   // whole run is about 5000 cycles
   initial begin
      repeat (60000) @(posedge clk);
      failures++;
      report_and_stop();
   end
endmodule
